// ==== verilog/board_status_pkg.sv ====
// Constants and carrier types for the board status, control and reset logic
package board_status_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] STATUS_BASE      = 32'hfff80000;
  localparam logic [31:0] STATUS_SPAN_MASK = 32'hfffe0000;
  localparam logic [31:0] POWERON_ANY_LO   = 32'hfffd0000;
  localparam logic [31:0] POWERON_ANY_HI   = 32'hfffdffff;
  localparam logic [31:0] POWERON_WR_LO    = 32'hfffa0000;
  localparam logic [31:0] POWERON_WR_HI    = 32'hfffcffff;

  // ----------------------------------------------------------------
  // Field positions in the status byte and the pin port
  // ----------------------------------------------------------------
  localparam int STAT_ACFAIL  = 7;
  localparam int STAT_CTRL    = 6;
  localparam int STAT_POWERON = 5;
  localparam int OPT_BITS     = 5;
  localparam int PIN_RTS      = 0;
  localparam int PIN_RBERR    = 1;
  localparam int PIN_LTO      = 2;
  localparam int PIN_CTS      = 3;
  localparam int PIN_GATE     = 4;
  localparam int PIN_FAULT    = 5;
  localparam int PIN_OUTREQ   = 6;
  localparam int PIN_SYSFAIL  = 7;
  localparam int IRQ_LINES    = 7;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic       POWERON_FLAG_RESET = 1'b0;
  localparam logic       OUTREQ_RESET       = 1'b0;
  localparam logic [1:0] GUARD_RESET        = 2'h3;
  localparam int         CLK_PERIOD_NS      = 20;
  localparam int         RESET_HOLD_NS      = 1000;
  localparam int         RESET_HOLD_CYCLES  = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_HOLD = 2'b10
  } reset_phase_type;

  // Raw board pins, all asynchronous to sys_clk
  typedef struct packed {
    logic                debug_request_to_send_in_n;
    logic                acfail_n;
    logic                sysfail_n;
    logic                sysreset_n;
    logic                reset_switch_n;
    logic                remote_reset_in_n;
    logic                watchdog_jumper;
    logic                controller_jumper_flag;
    logic [OPT_BITS-1:0] option_jumper_bits;
  } board_pins_type;

  localparam board_pins_type PINS_IDLE = 13'h1fe0;

  // Processor access to the shared 16-bit port and decode window
  typedef struct packed {
    logic        strobe;
    logic        write;
    logic        word;
    logic [31:0] addr;
    logic [15:0] wdata;
  } cpu_req_type;

  // Same-clock events from the bus and peripheral logic
  typedef struct packed {
    logic own_berr;
    logic rmw_lock;
    logic local_timeout;
    logic irq_raise;
    logic irq_ack;
    logic between_cycles;
    logic reset_instr;
    logic timer_b_out;
  } bus_events_type;

endpackage

// ==== verilog/sync_2ff.sv ====
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module sync_2ff #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (clk_en) begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // sync_2ff

// ==== verilog/hold_stretch.sv ====
// Holds a reset output for a fixed number of cycles after a start pulse
`timescale 1ns/1ps
module hold_stretch #(
  parameter int HOLD = 50
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  // Control
  input  wire logic start,
  output logic      active
);

  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] LOAD = CW'(HOLD - 1);

  logic [CW-1:0] cnt;

  // Load on start, count down while active
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
      cnt    <= '0;
    end else if (clk_en) begin
      if (start) begin
        active <= 1'b1;
        cnt    <= LOAD;
      end else if (active) begin
        if (cnt == '0) begin
          active <= 1'b0;
        end else begin
          cnt <= cnt - CW'(1);
        end
      end
    end
  end

endmodule // hold_stretch

// ==== verilog/board_status_reset_control.sv ====
// Board status byte, pin-port glue and reset arbitration
//
// How it works
// R1: Power-up, switch, watchdog, remote reset reset all; controller also drives system reset.
// R2: Incoming system reset resets everything but is never driven back.
// R3: Processor reset instruction resets only the serial controller and peripheral.
// R4: Every reset waits until the processor is between bus cycles.
// R5: With watchdog jumper fitted, timer B rising resets board, system reset if controller.
// R6: Status byte on upper lane, peripheral on lower lane of one 16-bit port.
// R7: Status answers byte and word reads; word reads place it on upper lanes.
// R8: Status ignores writes, never latches or interrupts; writes still reach the peripheral.
// R9: Bit 15 is 1 while AC-fail is low; also sent to interrupt handler.
// R10: Bit 14 is 1 when board is system controller.
// R11: Power-on flag cleared by power-up; bit 13 on words, bit 5 on bytes.
// R12: Power-on flag set by access in FFFDxxxx or writes in FFFA0000-FFFCFFFF.
// R13: Bits 12 to 8 read 0 for fitted option jumper, 1 when open.
// R14: Five pins are status inputs, three controls; unprogrammed controls read high.
// R15: Pin bit 0 reads 1 while debug request-to-send is low.
// R16: Pin bit 1 pulses low during own bus error or lock cycle.
// R17: Pin bit 2 pulses high during local timeout or lock cycle.
// R18: Debug clear-to-send is high only when pin bit 3 is driven 0.
// R19: Pin bit 4 high or input blocks the processor interrupt request lines, but not the AC-fail interrupt.
// R20: Pin bit 5 high or input lights fault, drives system-fail if not controller.
// R21: Pin bit 6 is the outbound request flag, cleared by ack and reset.
// R22: Pin bit 7 reads 1 while system-fail is low, so transitions can latch.
// R23: Reset sources are synchronised and the reset is held a minimum cycle count.
`timescale 1ns/1ps
module board_status_reset_control
  import board_status_pkg::*;
#(
  parameter int HOLD_CYCLES = board_status_pkg::RESET_HOLD_CYCLES
) (
  // Clock, reset and enable
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  input  wire logic                             clk_en,
  // Asynchronous board pins
  input  wire board_status_pkg::board_pins_type pins_in,
  // Processor port
  input  wire board_status_pkg::cpu_req_type    cpu_req,
  output logic [15:0]                           cpu_rdata,
  output logic                                  cpu_rvalid,
  // Peripheral side of the shared port
  input  wire logic [7:0]                       periph_rdata,
  output logic                                  periph_sel,
  output logic                                  periph_write,
  output logic [7:0]                            periph_wdata,
  // Peripheral general pins
  input  wire logic [7:0]                       gpio_out,
  input  wire logic [7:0]                       gpio_oe,
  output logic [7:0]                            general_pin_port,
  // Same-clock bus events
  input  wire board_status_pkg::bus_events_type bus_ev,
  // Interrupt gating
  input  wire logic [board_status_pkg::IRQ_LINES-1:0] irq_req_in,
  output logic [board_status_pkg::IRQ_LINES-1:0]      cpu_irq_out,
  output logic                                  acfail_irq_out,
  // Resets
  output logic                                  board_reset_out,
  output logic                                  periph_reset_out,
  output logic                                  sysreset_o,
  output logic                                  sysreset_oe,
  // Indicators and backplane fail
  output logic                                  debug_clear_to_send_out,
  output logic                                  interrupt_gate_n,
  output logic                                  board_fault_out,
  output logic                                  sysfail_o,
  output logic                                  sysfail_oe
);

  import board_status_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    reset_phase_type              phase;
    logic                         pend_full;
    logic                         pend_soft;
    logic                         pend_sys;
    logic                         pend_pwr;
    logic                         drive_sys;
    logic [1:0]                   guard;
    logic                         timer_b_q;
    logic                         poweron_flag_n;
    logic                         out_req;
    logic [15:0]                  rdata;
    logic                         rvalid;
    logic                         psel;
    logic                         pwrite;
    logic [7:0]                   pwdata;
    logic [7:0]                   pins;
    logic                         cts;
    logic                         gate_n;
    logic                         fault;
    logic                         fail_oe;
    logic [IRQ_LINES-1:0]         irq;
    logic                         acfail_irq;
  } state_type;

  localparam state_type STATE_RESET = '{
    phase:          PH_IDLE,
    pend_full:      1'b1,
    pend_soft:      1'b0,
    pend_sys:       1'b0,
    pend_pwr:       1'b1,
    drive_sys:      1'b0,
    guard:          GUARD_RESET,
    timer_b_q:      1'b0,
    poweron_flag_n: POWERON_FLAG_RESET,
    out_req:        OUTREQ_RESET,
    rdata:          16'h0000,
    rvalid:         1'b0,
    psel:           1'b0,
    pwrite:         1'b0,
    pwdata:         8'h00,
    pins:           8'hff,
    cts:            1'b0,
    gate_n:         1'b1,
    fault:          1'b1,
    fail_oe:        1'b0,
    irq:            '0,
    acfail_irq:     1'b0
  };

  state_type      st;
  state_type      next_st;
  board_pins_type ps;
  logic           start_full;
  logic           start_soft;
  logic           full_active;
  logic           soft_active;
  logic           poweron_hit;

  // Address window test, used for both power-on ranges
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and reset stretchers
  // ----------------------------------------------------------------
  // R23: synchronise sources
  sync_2ff #(
    .WIDTH     ($bits(board_pins_type)),
    .RESET_VAL (PINS_IDLE)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (pins_in),
    .sync_out (ps)
  );

  // R23: fixed hold length
  hold_stretch #(
    .HOLD (HOLD_CYCLES)
  ) u_full_hold (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .start   (start_full),
    .active  (full_active)
  );

  hold_stretch #(
    .HOLD (HOLD_CYCLES)
  ) u_soft_hold (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .start   (start_soft),
    .active  (soft_active)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] stat_byte;
    logic [7:0] eff;
    logic       hit_status;
    logic       ext_full;
    logic       sys_in;
    logic       wdog_edge;
    stat_byte   = 8'h00;
    eff         = 8'h00;
    hit_status  = 1'b0;
    ext_full    = 1'b0;
    sys_in      = 1'b0;
    wdog_edge   = 1'b0;
    next_st     = st;
    start_full  = 1'b0;
    start_soft  = 1'b0;
    poweron_hit = 1'b0;
    next_st.rvalid = 1'b0;
    next_st.psel   = 1'b0;

    // R5: watchdog on timer B rising edge
    wdog_edge = bus_ev.timer_b_out && !st.timer_b_q && ps.watchdog_jumper;
    next_st.timer_b_q = bus_ev.timer_b_out;
    // R1: local full-reset sources
    ext_full = !ps.reset_switch_n || !ps.remote_reset_in_n || wdog_edge;
    // R2: incoming system reset, own echo masked
    sys_in = !ps.sysreset_n && !st.drive_sys && (st.guard == 2'h0);

    // R4: wait for gap between cycles
    unique case (st.phase)
      PH_IDLE: begin
        if ((st.pend_full || st.pend_soft) && (st.guard == 2'h0)) begin
          next_st.phase = PH_WAIT;
        end
      end
      PH_WAIT: begin
        if (bus_ev.between_cycles) begin
          start_full = st.pend_full;
          // R3: soft reset hits the peripherals only
          start_soft = st.pend_soft || st.pend_full;
          // R1: controller drives system reset
          next_st.drive_sys = st.pend_sys || (st.pend_pwr && ps.controller_jumper_flag);
          // R11: power-up clears the flag
          if (st.pend_pwr) begin
            next_st.poweron_flag_n = 1'b0;
          end
          next_st.pend_full = 1'b0;
          next_st.pend_soft = 1'b0;
          next_st.pend_sys  = 1'b0;
          next_st.pend_pwr  = 1'b0;
          next_st.phase     = PH_HOLD;
        end
      end
      PH_HOLD: begin
        if (!full_active) begin
          next_st.drive_sys = 1'b0;
        end
        if (!full_active && !soft_active) begin
          next_st.phase = PH_IDLE;
        end
      end
      default: begin
        next_st.phase = PH_IDLE;
      end
    endcase

    // New requests win over the clear above
    if (ext_full || sys_in) begin
      next_st.pend_full = 1'b1;
    end
    if (ext_full && ps.controller_jumper_flag) begin
      next_st.pend_sys = 1'b1;
    end
    if (bus_ev.reset_instr) begin
      next_st.pend_soft = 1'b1;
    end

    // Echo guard after our own system reset drive
    if (st.drive_sys && !next_st.drive_sys) begin
      next_st.guard = GUARD_RESET;
    end else if (st.guard != 2'h0) begin
      next_st.guard = st.guard - 2'h1;
    end

    // R12: power-on flag set, wins over clear
    poweron_hit = cpu_req.strobe && (in_range(cpu_req.addr, POWERON_ANY_LO, POWERON_ANY_HI) ||
                  (cpu_req.write && in_range(cpu_req.addr, POWERON_WR_LO, POWERON_WR_HI)));
    if (poweron_hit) begin
      next_st.poweron_flag_n = 1'b1;
    end

    // R9: status byte assembly
    stat_byte[STAT_ACFAIL]          = !ps.acfail_n;
    // R10: controller jumper
    stat_byte[STAT_CTRL]            = ps.controller_jumper_flag;
    // R11: power-on flag position
    stat_byte[STAT_POWERON]         = st.poweron_flag_n;
    // R13: option jumpers
    stat_byte[OPT_BITS-1:0]         = ps.option_jumper_bits;

    // R6: shared port decode
    hit_status = cpu_req.strobe && ((cpu_req.addr & STATUS_SPAN_MASK) == STATUS_BASE);
    if (hit_status) begin
      if (!cpu_req.write) begin
        next_st.rvalid = 1'b1;
        // R7: word on upper lanes, byte in both
        if (cpu_req.word) begin
          next_st.rdata = {stat_byte, periph_rdata};
        end else if (cpu_req.addr[0]) begin
          next_st.rdata = {8'h00, periph_rdata};
        end else begin
          next_st.rdata = {stat_byte, stat_byte};
        end
      end
      // R8: writes pass to the peripheral only
      next_st.psel   = cpu_req.write || cpu_req.word || cpu_req.addr[0];
      next_st.pwrite = cpu_req.write;
      next_st.pwdata = (cpu_req.word || cpu_req.addr[0]) ? cpu_req.wdata[7:0] : cpu_req.wdata[15:8];
    end

    // R14: undriven controls pulled high
    eff = (gpio_out & gpio_oe) | ~gpio_oe;
    // R18: clear-to-send
    next_st.cts     = !eff[PIN_CTS];
    // R19: interrupt gate
    next_st.gate_n  = eff[PIN_GATE];
    next_st.irq     = eff[PIN_GATE] ? '0 : irq_req_in;
    // R20: fault lamp and system-fail
    next_st.fault   = eff[PIN_FAULT];
    next_st.fail_oe = eff[PIN_FAULT] && !ps.controller_jumper_flag;
    next_st.acfail_irq = !ps.acfail_n;

    // R21: outbound request flag, set wins
    if (bus_ev.irq_ack || start_full) begin
      next_st.out_req = 1'b0;
    end
    if (bus_ev.irq_raise) begin
      next_st.out_req = 1'b1;
    end

    // R15: debug request-to-send
    next_st.pins[PIN_RTS]     = !ps.debug_request_to_send_in_n;
    // R16: remote bus error pulse
    next_st.pins[PIN_RBERR]   = !(bus_ev.own_berr || bus_ev.rmw_lock);
    // R17: local timeout pulse
    next_st.pins[PIN_LTO]     = bus_ev.local_timeout || bus_ev.rmw_lock;
    next_st.pins[PIN_CTS]     = eff[PIN_CTS];
    next_st.pins[PIN_GATE]    = eff[PIN_GATE];
    next_st.pins[PIN_FAULT]   = eff[PIN_FAULT];
    next_st.pins[PIN_OUTREQ]  = next_st.out_req;
    // R22: system-fail status
    next_st.pins[PIN_SYSFAIL] = !ps.sysfail_n;
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= STATE_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cpu_rdata               = st.rdata;
  assign cpu_rvalid              = st.rvalid;
  assign periph_sel              = st.psel;
  assign periph_write            = st.pwrite;
  assign periph_wdata            = st.pwdata;
  assign general_pin_port        = st.pins;
  assign cpu_irq_out             = st.irq;
  assign acfail_irq_out          = st.acfail_irq;
  assign board_reset_out         = full_active;
  assign periph_reset_out        = soft_active;
  assign sysreset_o              = 1'b0;
  // R2: drive only for local sources
  assign sysreset_oe             = st.drive_sys;
  assign debug_clear_to_send_out = st.cts;
  assign interrupt_gate_n        = st.gate_n;
  assign board_fault_out         = st.fault;
  assign sysfail_o               = 1'b0;
  assign sysfail_oe              = st.fail_oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [15:0] hold_len;

  // Length of the current full reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_len <= 16'h0000;
    end else if (clk_en) begin
      hold_len <= full_active ? hold_len + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_full_start;
    $rose(board_reset_out);
  endsequence

  property p_wait_gap;
    s_full_start |-> $past(bus_ev.between_cycles) && $past(st.phase == PH_WAIT);
  endproperty
  a_wait_gap: assert property (p_wait_gap) else $error("reset began during a bus cycle"); // R4

  property p_hold_len;
    $fell(board_reset_out) |-> hold_len >= 16'(HOLD_CYCLES);
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("full reset too short"); // R23

  property p_full_covers;
    board_reset_out |-> periph_reset_out;
  endproperty
  a_full_covers: assert property (p_full_covers) else $error("full reset missed peripherals"); // R1

  property p_sys_drive;
    sysreset_oe |-> board_reset_out || $past(board_reset_out);
  endproperty
  a_sys_drive: assert property (p_sys_drive) else $error("system reset driven outside full reset"); // R2

  property p_status_ctrl;
    $past(clk_en) && cpu_rvalid && $past(cpu_req.word) |-> cpu_rdata[14] == $past(ps.controller_jumper_flag);
  endproperty
  a_status_ctrl: assert property (p_status_ctrl) else $error("controller bit wrong"); // R10

  property p_cts;
    $past(clk_en) |-> debug_clear_to_send_out == ($past(gpio_oe[PIN_CTS]) && !$past(gpio_out[PIN_CTS]));
  endproperty
  a_cts: assert property (p_cts) else $error("clear-to-send wrong"); // R18

  property p_gate;
    (cpu_irq_out != '0) |-> !interrupt_gate_n;
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt passed a closed gate"); // R19

  property p_fail;
    sysfail_oe |-> board_fault_out;
  endproperty
  a_fail: assert property (p_fail) else $error("system-fail without fault lamp"); // R20

  property p_poweron;
    $past(clk_en) && $past(poweron_hit) |-> st.poweron_flag_n;
  endproperty
  a_poweron: assert property (p_poweron) else $error("power-on flag not set"); // R12

  property p_berr_pulse;
    $past(clk_en) && $past(bus_ev.own_berr) |-> !general_pin_port[PIN_RBERR];
  endproperty
  a_berr_pulse: assert property (p_berr_pulse) else $error("bus error pulse missing"); // R16

endmodule // board_status_reset_control

// ==== verification/periph_model.sv ====
// Peripheral register model on the lower byte of the shared port
`timescale 1ns/1ps
module periph_model (
  // Clock
  input  wire logic       sys_clk,
  // Peripheral side
  input  wire logic       periph_sel,
  input  wire logic       periph_write,
  input  wire logic [7:0] periph_wdata,
  output logic      [7:0] periph_rdata
);
  logic [7:0] data_reg = 8'ha5;

  always @(posedge sys_clk) begin
    if (periph_sel && periph_write) begin
      data_reg <= periph_wdata;
    end
  end

  // Register contents always on the read lane
  assign periph_rdata = data_reg;
endmodule // periph_model

// ==== verification/testbench.sv ====
// Self-checking bench for the board status, control and reset logic
`timescale 1ns/1ps
module testbench;
  import board_status_pkg::*;
  localparam int HOLD = 4;
  logic           sys_clk = 1'b0;
  logic           rst = 1'b1;
  board_pins_type pins;
  cpu_req_type    req = '0;
  bus_events_type ev = 8'h04;  // Processor idle between cycles
  logic [7:0]     gout = 8'h00, goe = 8'h00, prd, pwd, gpp;
  logic [6:0]     irq = 7'h55, cirq;
  logic [15:0]    rd;
  logic           rv, psel, pwr, cts, gate, flt, sfo, sfoe, brst, prst, sro, sroe, acirq;
  int             failures = 0, n_compared = 0, n;

  // Clock
  always #10 sys_clk = ~sys_clk;

  board_status_reset_control #(.HOLD_CYCLES(HOLD)) u_board_status_reset_control (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .pins_in(pins), .cpu_req(req),
    .cpu_rdata(rd), .cpu_rvalid(rv), .periph_rdata(prd), .periph_sel(psel),
    .periph_write(pwr), .periph_wdata(pwd), .gpio_out(gout), .gpio_oe(goe),
    .general_pin_port(gpp), .bus_ev(ev), .irq_req_in(irq), .cpu_irq_out(cirq),
    .acfail_irq_out(acirq), .board_reset_out(brst), .periph_reset_out(prst),
    .sysreset_o(sro), .sysreset_oe(sroe), .debug_clear_to_send_out(cts),
    .interrupt_gate_n(gate), .board_fault_out(flt), .sysfail_o(sfo), .sysfail_oe(sfoe));

  periph_model u_periph_model (
    .sys_clk(sys_clk), .periph_sel(psel), .periph_write(pwr),
    .periph_wdata(pwd), .periph_rdata(prd));

  // Comparison and verdict
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // One strobed access, settled just after the answer edge
  task automatic access(input logic w, input logic wd, input logic [31:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, w, wd, a, d};
    @(posedge sys_clk);
    req.strobe <= 1'b0;
    #1;
  endtask

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask

  // Power-up reset: defaults, start, hold length, system reset drive
  task automatic t_powerup;
    chk("rst_pins", 16'h01ff, {7'h00, gate, gpp});
    @(posedge sys_clk);
    rst <= 1'b0;
    for (n = 0; n < 30 && brst !== 1'b1; n++) tick();
    chk("sysreset_oe", 16'h0003, {14'h0, sroe, prst});
    for (n = 0; n < 30 && brst === 1'b1; n++) tick();
    chk("hold", 16'(HOLD), 16'(n));
    $display("test powerup done");
  endtask

  // Status byte layout, power-on flag, writes to the shared port
  task automatic t_status;
    access(1'b0, 1'b1, 32'hfff80000, 16'h0);
    chk("word_rd", 16'hcaa5, {rv ? rd[15:8] : 8'hxx, rd[7:0]});
    access(1'b0, 1'b0, 32'hfffd0000, 16'h0);
    chk("no_rvalid", 16'h0000, {14'h0, rv, psel});
    access(1'b0, 1'b0, 32'hfff80000, 16'h0);
    chk("byte_rd", 16'heaea, rd);
    access(1'b1, 1'b0, 32'hfff80000, 16'h3c00);
    chk("wr_noans", 16'h0001, {14'h0, rv, psel});
    access(1'b0, 1'b1, 32'hfff80000, 16'h0);
    chk("word_rd2", 16'hea3c, rd);
    $display("test status done");
  endtask

  // Control pins as inputs, then driven low, then bus events
  task automatic t_pins;
    tick();
    chk("ctl_in", 16'h06ba, {4'h0, cts, gate, flt, sfoe, gpp});
    chk("irq_in", 16'h0000, {9'h0, cirq});
    @(posedge sys_clk);
    goe <= 8'h38;
    pins.debug_request_to_send_in_n <= 1'b0;
    tick();
    tick();
    tick();
    chk("ctl_out", {4'h8, 5'h0, irq}, {cts, gate, flt, sfoe, 5'h0, cirq});
    chk("pins_out", 16'h0083, {8'h0, gpp});
    @(posedge sys_clk);
    ev <= 8'hb4;
    @(posedge sys_clk);
    ev <= 8'h04;
    #1;
    chk("pins_ev", 16'h00c5, {8'h0, gpp});
    tick();
    chk("pins_ret", 16'h00c3, {8'h0, gpp});
    $display("test pins done");
  endtask

  // Reset instruction touches only the peripheral reset
  task automatic t_instr;
    @(posedge sys_clk);
    ev <= 8'h06;
    @(posedge sys_clk);
    ev <= 8'h04;
    for (n = 0; n < 30 && prst !== 1'b1; n++) tick();
    chk("instr_rst", 16'h0001, {14'h0, brst, prst});
    chk("instr_keep", 16'h0001, {15'h0, gpp[6]});
    $display("test instr done");
  endtask

  // Watchdog expiry held off by a bus cycle, then a full reset
  task automatic t_wdog;
    @(posedge sys_clk);
    ev <= 8'h01;  // Timer B high, processor mid-cycle
    repeat (5) tick();
    chk("wdog_wait", 16'h0000, {15'h0, brst});
    @(posedge sys_clk);
    ev <= 8'h05;
    for (n = 0; n < 30 && brst !== 1'b1; n++) tick();
    chk("wdog_rst", 16'h0007, {13'h0, sroe, prst, brst});
    chk("outbound_request_flag_clr", 16'h0000, {15'h0, gpp[6]});
    for (n = 0; n < 30 && brst === 1'b1; n++) tick();
    chk("wdog_hold", 16'(HOLD), 16'(n));
    $display("test wdog done");
  endtask

  // Watchdog against a hang
  initial begin
    #200000;
    failures++;
    finish_test();
  end

  // Main sequence
  initial begin
    pins = PINS_IDLE;
    pins.acfail_n = 1'b0;
    pins.sysfail_n = 1'b0;
    pins.controller_jumper_flag = 1'b1;
    pins.option_jumper_bits = 5'h0a;
    repeat (16) @(posedge sys_clk);
    #1;
    t_powerup();
    t_status();
    t_pins();
    t_instr();
    t_wdog();
    finish_test();
  end
endmodule // testbench
